/* verilog/ns_indicator_pkg.sv */
// Constants for the network status lamp controller.
// Assumes a single 250 MHz system clock.
package lamp_pattern_pkg;
    localparam int unsigned CLK_HZ = 250000000;
    localparam int unsigned FLASH_HALF_MS = 500;   // Half period of a flash
    localparam int unsigned GROUP_PAUSE_MS = 2000; // Pause between count groups
    localparam int unsigned FLASH_HALF_CYCLES = (CLK_HZ / 1000) * FLASH_HALF_MS;
    localparam int unsigned GROUP_PAUSE_CYCLES = (CLK_HZ / 1000) * GROUP_PAUSE_MS;
    localparam int unsigned MAX_CONNECTIONS = 7;
    localparam int unsigned CONN_COUNT_WIDTH = 3;
    localparam logic [1:0] PROTO_CIP = 2'h0;
    localparam logic [1:0] PROTO_MODBUS = 2'h1;
    localparam logic [1:0] PROTO_PROFINET = 2'h2;
    typedef enum logic [1:0] {
        BLINK_PAUSE = 2'b00,
        BLINK_ON = 2'b01,
        BLINK_OFF = 2'b10
    } blink_state_type;
endpackage

/* verilog/network_status_indicator.sv */
// Network status lamp controller: protocol state to red/green patterns.
// Assumes status inputs synchronous to mclk and held as levels.
// Overview of operation
// RULE1 - CIP: link without connection flashes green
// RULE2 - CIP: valid network and connection, steady green
// RULE3 - Modbus: green blink per connection, 2 s pause
// RULE4 - Modbus: never steady green, dark without connections
// RULE5 - PROFINET: controller in STOP flashes green
// RULE6 - PROFINET: controller in RUN steady green
// RULE7 - PROFINET: dark on duplicate, name mismatch, disconnected
// RULE8 - Address or protocol changed: flash red until reset
// RULE9 - CIP: duplicate IP address shows steady red
// RULE10 - Self-test alternates; CIP timeout flashes red (code flashes red on timeout only while module_status_green is high)
module network_status_indicator #(
    parameter int unsigned FLASH_HALF = lamp_pattern_pkg::FLASH_HALF_CYCLES,
    parameter int unsigned GROUP_PAUSE = lamp_pattern_pkg::GROUP_PAUSE_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [1:0] protocol_sel,
    input wire logic self_test,
    input wire logic link_up,
    input wire logic cip_conn_open,
    input wire logic cip_conn_timeout,
    input wire logic duplicate_ip,
    input wire logic [lamp_pattern_pkg::CONN_COUNT_WIDTH-1:0] tcp_conn_count,
    input wire logic io_ctrl_connected,
    input wire logic io_ctrl_run,
    input wire logic name_mismatch,
    input wire logic config_changed,
    input wire logic module_status_green,
    output logic lamp_green,
    output logic lamp_red
);
    logic [31:0] flash_cnt_reg;
    logic flash_phase_reg;
    logic change_latched_reg;
    lamp_pattern_pkg::blink_state_type blink_reg;
    logic [31:0] blink_cnt_reg;
    logic [lamp_pattern_pkg::CONN_COUNT_WIDTH-1:0] blinks_left_reg;
    logic green_next;
    logic red_next;
    logic flash_tick;

    assign flash_tick = (flash_cnt_reg == FLASH_HALF - 1);

    // Free running flash base, shared so red and green stay in phase
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flash_cnt_reg <= '0;
            flash_phase_reg <= 1'b0;
        end else if (flash_tick) begin
            flash_cnt_reg <= '0;
            flash_phase_reg <= ~flash_phase_reg;
        end else begin
            flash_cnt_reg <= flash_cnt_reg + 32'h1;
        end
    end

    // Change request sticks; only a power cycle (reset) clears it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            change_latched_reg <= 1'b0;
        end else if (config_changed) begin
            change_latched_reg <= 1'b1; // [RULE8]
        end
    end

    // Connection count sequencer: N half-period blinks then long pause
    // Count loads only as a pause ends; a change mid-group shows next group
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            blink_reg <= lamp_pattern_pkg::BLINK_PAUSE;
            blink_cnt_reg <= '0;
            blinks_left_reg <= '0;
        end else begin
            case (blink_reg)
                lamp_pattern_pkg::BLINK_PAUSE: begin
                    if (blink_cnt_reg >= GROUP_PAUSE - 1) begin
                        blink_cnt_reg <= '0;
                        if (tcp_conn_count != '0) begin // [RULE3]
                            blinks_left_reg <= tcp_conn_count;
                            blink_reg <= lamp_pattern_pkg::BLINK_ON;
                        end
                    end else begin
                        blink_cnt_reg <= blink_cnt_reg + 32'h1;
                    end
                end
                lamp_pattern_pkg::BLINK_ON: begin
                    if (blink_cnt_reg == FLASH_HALF - 1) begin
                        blink_cnt_reg <= '0;
                        blinks_left_reg <= blinks_left_reg - 3'h1;
                        blink_reg <= lamp_pattern_pkg::BLINK_OFF;
                    end else begin
                        blink_cnt_reg <= blink_cnt_reg + 32'h1;
                    end
                end
                lamp_pattern_pkg::BLINK_OFF: begin
                    if (blinks_left_reg == '0) begin
                        blink_cnt_reg <= '0;
                        blink_reg <= lamp_pattern_pkg::BLINK_PAUSE; // [RULE3]
                    end else if (blink_cnt_reg == FLASH_HALF - 1) begin
                        blink_cnt_reg <= '0;
                        blink_reg <= lamp_pattern_pkg::BLINK_ON;
                    end else begin
                        blink_cnt_reg <= blink_cnt_reg + 32'h1;
                    end
                end
                default: begin
                    blink_reg <= lamp_pattern_pkg::BLINK_PAUSE;
                    blink_cnt_reg <= '0;
                end
            endcase
        end
    end

    // Pattern selection; self-test and change latch override protocol state
    always_comb begin
        green_next = 1'b0;
        red_next = 1'b0;
        if (self_test) begin
            green_next = flash_phase_reg; // [RULE10]
            red_next = ~flash_phase_reg;
        end else if (change_latched_reg) begin
            red_next = flash_phase_reg; // [RULE8]
        end else begin
            case (protocol_sel)
                lamp_pattern_pkg::PROTO_CIP: begin
                    if (duplicate_ip) begin
                        red_next = 1'b1; // [RULE9]
                    end else if (cip_conn_timeout && module_status_green) begin
                        red_next = flash_phase_reg; // [RULE10]
                    end else if (link_up && cip_conn_open) begin
                        green_next = 1'b1; // [RULE2]
                    end else if (link_up) begin
                        green_next = flash_phase_reg; // [RULE1]
                    end
                end
                lamp_pattern_pkg::PROTO_MODBUS: begin
                    // Only the blink sequencer drives green here [RULE4]
                    green_next = link_up && (tcp_conn_count != '0) && (blink_reg == lamp_pattern_pkg::BLINK_ON);
                end
                lamp_pattern_pkg::PROTO_PROFINET: begin
                    if (duplicate_ip || name_mismatch || !io_ctrl_connected) begin
                        green_next = 1'b0; // [RULE7]
                    end else if (io_ctrl_run) begin
                        green_next = 1'b1; // [RULE6]
                    end else begin
                        green_next = flash_phase_reg; // [RULE5]
                    end
                end
                default: begin
                    green_next = 1'b0;
                end
            endcase
        end
    end

    // Registered lamp drive avoids glitches on the pins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lamp_green <= 1'b0;
            lamp_red <= 1'b0;
        end else begin
            lamp_green <= green_next;
            lamp_red <= red_next;
        end
    end

    // Pattern checks; inputs sampled at one edge show on the lamps at the next
    never_both_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE10]
        !(lamp_green && lamp_red)) else $error("both lamps lit");
    selftest_alt_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE10]
        self_test |=> (lamp_green != lamp_red)) else $error("self-test not alternating");
    change_red_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE8]
        (change_latched_reg && !self_test) |=> !lamp_green) else $error("green during change");
    change_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE8]
        change_latched_reg |=> change_latched_reg) else $error("change latch cleared");
    cip_dup_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE9]
        (!self_test && !change_latched_reg && protocol_sel == lamp_pattern_pkg::PROTO_CIP && duplicate_ip)
        |=> lamp_red) else $error("no steady red on duplicate");
    cip_steady_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
        (!self_test && !change_latched_reg && protocol_sel == lamp_pattern_pkg::PROTO_CIP && !duplicate_ip
        && !(cip_conn_timeout && module_status_green) && link_up && cip_conn_open) |=> lamp_green)
        else $error("no steady green in cip");
    pn_dark_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE7]
        (!self_test && protocol_sel == lamp_pattern_pkg::PROTO_PROFINET && !io_ctrl_connected)
        |=> !lamp_green) else $error("green without controller");
    pn_run_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE6]
        (!self_test && !change_latched_reg && protocol_sel == lamp_pattern_pkg::PROTO_PROFINET
        && io_ctrl_connected && io_ctrl_run && !duplicate_ip && !name_mismatch) |=> lamp_green)
        else $error("no steady green in run");
    mb_dark_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE4]
        (!self_test && protocol_sel == lamp_pattern_pkg::PROTO_MODBUS && tcp_conn_count == '0)
        |=> !lamp_green) else $error("green without tcp connection");
    mb_gap_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE4]
        (!self_test && protocol_sel == lamp_pattern_pkg::PROTO_MODBUS && blink_reg != lamp_pattern_pkg::BLINK_ON)
        |=> !lamp_green) else $error("modbus green outside blink");
    mb_on_len_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE4]
        (blink_reg == lamp_pattern_pkg::BLINK_ON && blink_cnt_reg == FLASH_HALF - 1)
        |=> blink_reg == lamp_pattern_pkg::BLINK_OFF) else $error("modbus blink too long");
    mb_pause_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE3]
        (blink_reg == lamp_pattern_pkg::BLINK_OFF && blinks_left_reg == '0) |=>
        blink_reg == lamp_pattern_pkg::BLINK_PAUSE) else $error("no pause after group");
    flash_green_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
        (!self_test && !change_latched_reg && protocol_sel == lamp_pattern_pkg::PROTO_CIP && link_up
        && !cip_conn_open && !duplicate_ip && !cip_conn_timeout) |=> (lamp_green == $past(flash_phase_reg)))
        else $error("cip link flash wrong");
    pn_stop_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE5]
        (!self_test && !change_latched_reg && protocol_sel == lamp_pattern_pkg::PROTO_PROFINET
        && io_ctrl_connected && !io_ctrl_run && !duplicate_ip && !name_mismatch)
        |=> (lamp_green == $past(flash_phase_reg))) else $error("stop flash wrong");

    // Main scenarios that the bench is expected to reach
    selftest_c: cover property (@(posedge mclk) disable iff (!rst_n) self_test && lamp_red ##1 lamp_green);
    mb_group_c: cover property (@(posedge mclk) disable iff (!rst_n)
        blink_reg == lamp_pattern_pkg::BLINK_OFF ##1 blink_reg == lamp_pattern_pkg::BLINK_ON);
    change_c: cover property (@(posedge mclk) disable iff (!rst_n) change_latched_reg && lamp_red);
    pn_run_c: cover property (@(posedge mclk) disable iff (!rst_n)
        protocol_sel == lamp_pattern_pkg::PROTO_PROFINET && lamp_green);
    cip_timeout_c: cover property (@(posedge mclk) disable iff (!rst_n)
        protocol_sel == lamp_pattern_pkg::PROTO_CIP && cip_conn_timeout && module_status_green && lamp_red);
endmodule

/* verification/lamp_model.sv */
// Bi-colour lamp as seen from outside: green strikes and dark time.
// Assumes lamp drive lines are registered on mclk and active high.
module lamp_model (
    input wire logic mclk,
    input wire logic lamp_green,
    input wire logic lamp_red,
    output int green_rises,
    output int dark_run
);
    timeunit 1ns;
    timeprecision 1ps;
    logic green_last = 1'b0;
    // Never cleared; the bench works on differences, so reset cannot skew it
    always @(posedge mclk) begin
        if (lamp_green === 1'b1 && green_last !== 1'b1) begin
            green_rises <= green_rises + 1;
        end
        // Dark means neither colour lit, so a red pattern never reads as a pause
        dark_run <= (lamp_green === 1'b1 || lamp_red === 1'b1) ? 0 : dark_run + 1;
        green_last <= lamp_green;
    end
endmodule

/* verification/tb.sv */
// Self-checking bench for the network status lamp controller.
// Assumes short flash and pause counts so patterns show within tens of cycles.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 4;
    localparam int PAUSE = 16;
    logic mclk = 1'b0, rst_n = 1'b0, self_test = 1'b0, link_up = 1'b0;
    logic cip_conn_open = 1'b0, cip_conn_timeout = 1'b0, duplicate_ip = 1'b0;
    logic io_ctrl_connected = 1'b0, io_ctrl_run = 1'b0, name_mismatch = 1'b0;
    logic config_changed = 1'b0, module_status_green = 1'b0;
    logic [1:0] protocol_sel = 2'h0;
    logic [2:0] tcp_conn_count = 3'h0;
    logic lamp_green, lamp_red;
    int green_rises, dark_run, failures = 0, n_checks = 0;
    network_status_indicator #(.FLASH_HALF(HALF), .GROUP_PAUSE(PAUSE)) network_status_indicator_i (
        .mclk, .rst_n, .protocol_sel, .self_test, .link_up, .cip_conn_open, .cip_conn_timeout,
        .duplicate_ip, .tcp_conn_count, .io_ctrl_connected, .io_ctrl_run, .name_mismatch,
        .config_changed, .module_status_green, .lamp_green, .lamp_red);
    lamp_model lamp_model_i (.mclk, .lamp_green, .lamp_red, .green_rises, .dark_run);
    always #2 mclk = ~mclk;
    // Inputs always move 1 ns after the rising edge
    task automatic at_edge();
        @(posedge mclk);
        #1;
    endtask
    task automatic check(input int got, input int exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // 0 dark, 1 flashing, 2 steady; window spans three flash periods
    task automatic observe(input int exp_g, input int exp_r);
        int g;
        int r;
        g = 0;
        r = 0;
        repeat (3) at_edge();
        repeat (24) begin
            at_edge();
            g += int'(lamp_green === 1'b1);
            r += int'(lamp_red === 1'b1);
        end
        check((g == 0) ? 0 : (g == 24) ? 2 : 1, exp_g);
        check((r == 0) ? 0 : (r == 24) ? 2 : 1, exp_r);
    endtask
    // Counts one whole group; a dark run past one off phase marks the pause
    task automatic modbus_group(input int n);
        int k;
        int base;
        tcp_conn_count = 3'(n);
        // One edge first, so a group that has just lit is not taken for a pause
        at_edge();
        k = 0;
        while (dark_run < HALF + 3 && k < 500) begin
            at_edge();
            k++;
        end
        base = green_rises;
        k = 0;
        while ((green_rises == base || dark_run < HALF + 3) && k < 500) begin
            at_edge();
            k++;
        end
        check(green_rises - base, n);
        k = 0;
        while (lamp_green !== 1'b1 && k < 500) begin
            at_edge();
            k++;
        end
        check(k + HALF + 3, PAUSE + 1);
    endtask
    task automatic t_self_test();
        self_test = 1'b1;
        observe(1, 1);
        self_test = 1'b0;
        $display("test self_test done");
    endtask
    task automatic t_cip();
        protocol_sel = 2'h0;
        link_up = 1'b1;
        observe(1, 0);
        cip_conn_open = 1'b1;
        observe(2, 0);
        cip_conn_timeout = 1'b1;
        observe(2, 0);
        module_status_green = 1'b1;
        observe(0, 1);
        duplicate_ip = 1'b1;
        observe(0, 2);
        {duplicate_ip, cip_conn_timeout, module_status_green} = 3'h0;
        $display("test cip done");
    endtask
    task automatic t_modbus();
        protocol_sel = 2'h1;
        duplicate_ip = 1'b1;
        observe(0, 0);
        duplicate_ip = 1'b0;
        modbus_group(3);
        modbus_group(7);
        modbus_group(1);
        $display("test modbus done");
    endtask
    task automatic t_profinet();
        protocol_sel = 2'h2;
        io_ctrl_connected = 1'b1;
        observe(1, 0);
        io_ctrl_run = 1'b1;
        observe(2, 0);
        for (int i = 0; i < 3; i++) begin
            {duplicate_ip, name_mismatch, io_ctrl_connected} = (i == 2) ? 3'h0 : (i == 0 ? 3'h5 : 3'h3);
            observe(0, 0);
        end
        // Unused protocol code must leave the lamp dark
        protocol_sel = 2'h3;
        observe(0, 0);
        io_ctrl_connected = 1'b1;
        $display("test profinet done");
    endtask
    // The change latch must outlive both its pulse and a protocol switch
    task automatic t_change();
        config_changed = 1'b1;
        at_edge();
        config_changed = 1'b0;
        observe(0, 1);
        protocol_sel = 2'h0;
        observe(0, 1);
        rst_n = 1'b0;
        repeat (2) at_edge();
        rst_n = 1'b1;
        observe(2, 0);
        $display("test change done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Whole run is under 3000 cycles; 20000 leaves room
    initial begin
        #80000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        t_self_test();
        t_cip();
        t_modbus();
        t_profinet();
        t_change();
        report_and_stop();
    end
endmodule
